// ===== logic/lccr_pkg.sv
// Package with register map, reset values, timeout codes, state encoding and timing constants for the charger control block
package lccr_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] LCCR_ADDR_SETPOINTS = 8'h08;
  localparam logic [7:0] LCCR_ADDR_STATUS = 8'h09;
  localparam logic [7:0] LCCR_ADDR_RESERVED = 8'h0a;
  localparam logic [7:0] LCCR_ADDR_SUSPEND = 8'h0b;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [3:0] LCCR_CURRENT_RST = 4'h4;
  localparam logic [2:0] LCCR_VOLT_RST = 3'h5;
  localparam logic [1:0] LCCR_TMO_RST = 2'h0;
  // ----------------------------------------
  // Timeout selection codes
  // ----------------------------------------
  localparam logic [1:0] LCCR_TMO_60M = 2'h0;
  localparam logic [1:0] LCCR_TMO_OFF = 2'h1;
  localparam logic [1:0] LCCR_TMO_30M = 2'h2;
  localparam logic [1:0] LCCR_TMO_45M = 2'h3;
  // Timeouts in tenths of a minute (3.0 h = 1800, 1.5 h = 900, 2.2 h = 1320)
  localparam int LCCR_PRE_60M_DMIN = 600;
  localparam int LCCR_PRE_30M_DMIN = 300;
  localparam int LCCR_PRE_45M_DMIN = 450;
  localparam int LCCR_TOT_3H_DMIN = 1800;
  localparam int LCCR_TOT_1H5_DMIN = 900;
  localparam int LCCR_TOT_2H2_DMIN = 1320;
  // ----------------------------------------
  // Timebase: one tick per tenth of a minute (6 s) at 125 MHz
  // ----------------------------------------
  localparam int LCCR_CLK_HZ = 125000000;
  localparam int LCCR_TICK_MS = 6000;
  localparam longint LCCR_TICK_CYC = longint'(LCCR_CLK_HZ) * LCCR_TICK_MS / 1000;
  localparam int LCCR_TMR_W = 11;
  // ----------------------------------------
  // Charge states, Gray coded along the usual path
  // ----------------------------------------
  typedef enum logic [2:0] {
    LCCR_ST_SUSPEND = 3'h0,
    LCCR_ST_PRECOND = 3'h1,
    LCCR_ST_FAST = 3'h3,
    LCCR_ST_TOPOFF = 3'h2,
    LCCR_ST_SLEEP = 3'h6,
    LCCR_ST_FAULT = 3'h7,
    LCCR_ST_NOBAT = 3'h5
  } lccr_state_e;
endpackage

// ===== logic/lccr_sync.sv
// Two-flop synchroniser, one per bit
`timescale 1ns/1ps
module lccr_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  // Per-bit chain; the first stage feeds only the second
  for (genvar g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        meta_q[g] <= 1'b0;
        sync_q[g] <= 1'b0;
      end else begin
        meta_q[g] <= d_i[g];
        sync_q[g] <= meta_q[g];
      end
    end
  end
  assign q_o = sync_q;
endmodule

// ===== logic/lccr_charger_ctrl.sv
// Charger control: byte registers, comparator synchronisers, charge state machine and safety timers
`timescale 1ns/1ps
module lccr_charger_ctrl import lccr_pkg::*; #(
  parameter longint TICK_CYC = LCCR_TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port from the serial interface
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Pin and comparator inputs, asynchronous
  input wire logic charge_enable_n_i,
  input wire logic supply_above_cell_i,
  input wire logic supply_above_uvlo_i,
  input wire logic cell_presence_input_i,
  input wire logic cell_above_precond_i,
  input wire logic cell_at_term_i,
  input wire logic current_below_eoc_i,
  input wire logic cell_below_restart_i,
  // Analogue loop controls
  output logic charger_unit_en_o,
  output logic cc_mode_o,
  output logic cv_mode_o,
  output logic precond_mode_o,
  output logic [3:0] fast_current_sel_o,
  output logic [2:0] term_voltage_sel_o,
  output logic ldo123_en_o,
  output logic charge_current_monitor_oe_n_o
);
  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [7:0] raw_in;
  logic [7:0] syn;
  assign raw_in = {cell_below_restart_i, current_below_eoc_i, cell_at_term_i, cell_above_precond_i,
                   cell_presence_input_i, supply_above_uvlo_i, supply_above_cell_i, charge_enable_n_i};
  lccr_sync #(.W(8)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(raw_in),
    .q_o(syn)
  );
  logic enable_n_s, above_cell_s, above_uvlo_s, present_s, precond_ok_s, at_term_s, eoc_s, restart_s;
  assign {restart_s, eoc_s, at_term_s, precond_ok_s, present_s, above_uvlo_s, above_cell_s, enable_n_s} = syn;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [3:0] fast_current_sel_q;
  logic [2:0] term_voltage_sel_q;
  logic [1:0] safety_timeout_sel_q;
  logic suspend_charge_q;
  logic wr_setp, wr_stat, wr_susp;
  assign wr_setp = reg_wr_i && (reg_addr_i == LCCR_ADDR_SETPOINTS);
  assign wr_stat = reg_wr_i && (reg_addr_i == LCCR_ADDR_STATUS);
  assign wr_susp = reg_wr_i && (reg_addr_i == LCCR_ADDR_SUSPEND);

  // Read-only bits are never stored, so writes to them have no effect
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fast_current_sel_q <= LCCR_CURRENT_RST;
      term_voltage_sel_q <= LCCR_VOLT_RST;
      safety_timeout_sel_q <= LCCR_TMO_RST;
      suspend_charge_q <= 1'b0;
    end else begin
      if (wr_setp) begin
        fast_current_sel_q <= reg_wdata_i[7:4];
        term_voltage_sel_q <= reg_wdata_i[2:0];
      end
      if (wr_stat) begin
        safety_timeout_sel_q <= reg_wdata_i[7:6];
      end
      if (wr_susp) begin
        suspend_charge_q <= reg_wdata_i[0];
      end
    end
  end

  // ----------------------------------------
  // Qualification
  // ----------------------------------------
  logic supply_ok, may_run, stop_req;
  assign supply_ok = above_cell_s && above_uvlo_s;
  assign may_run = supply_ok && !enable_n_s && !suspend_charge_q;
  // Pin high, suspend bit or supply loss always drop to suspend, even from fault
  assign stop_req = !may_run;

  // ----------------------------------------
  // Safety timers
  // ----------------------------------------
  logic [LCCR_TMR_W-1:0] pre_lim, tot_lim;
  logic tmr_off;
  assign tmr_off = (safety_timeout_sel_q == LCCR_TMO_OFF);
  assign pre_lim = (safety_timeout_sel_q == LCCR_TMO_30M) ? LCCR_TMR_W'(LCCR_PRE_30M_DMIN) :
                   (safety_timeout_sel_q == LCCR_TMO_45M) ? LCCR_TMR_W'(LCCR_PRE_45M_DMIN) :
                   LCCR_TMR_W'(LCCR_PRE_60M_DMIN);
  assign tot_lim = (safety_timeout_sel_q == LCCR_TMO_30M) ? LCCR_TMR_W'(LCCR_TOT_1H5_DMIN) :
                   (safety_timeout_sel_q == LCCR_TMO_45M) ? LCCR_TMR_W'(LCCR_TOT_2H2_DMIN) :
                   LCCR_TMR_W'(LCCR_TOT_3H_DMIN);

  lccr_state_e state_q, state_d;
  logic [31:0] div_q;
  logic [LCCR_TMR_W-1:0] pre_cnt_q, tot_cnt_q;
  logic tick, timing, new_cycle, pre_exp, tot_exp;
  assign tick = (div_q == 32'(TICK_CYC - 1));
  assign timing = (state_q == LCCR_ST_PRECOND) || (state_q == LCCR_ST_FAST) || (state_q == LCCR_ST_TOPOFF);
  // A restart from sleep is a new cycle too, so it gets the full total budget again
  assign new_cycle = ((state_d == LCCR_ST_PRECOND) && (state_q != LCCR_ST_PRECOND)) ||
                     ((state_q == LCCR_ST_SLEEP) && (state_d == LCCR_ST_FAST));
  assign pre_exp = !tmr_off && (pre_cnt_q >= pre_lim);
  assign tot_exp = !tmr_off && (tot_cnt_q >= tot_lim);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_q <= 32'h0;
      pre_cnt_q <= '0;
      tot_cnt_q <= '0;
    end else if (new_cycle) begin
      div_q <= 32'h0;
      pre_cnt_q <= '0;
      tot_cnt_q <= '0;
    end else if (timing && !tmr_off) begin
      div_q <= tick ? 32'h0 : div_q + 32'h1;
      if (tick && !pre_exp && state_q == LCCR_ST_PRECOND) begin
        pre_cnt_q <= pre_cnt_q + 1'b1;
      end
      if (tick && !tot_exp) begin
        tot_cnt_q <= tot_cnt_q + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Charge state machine
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    if (stop_req) begin
      state_d = LCCR_ST_SUSPEND;
    end else begin
      case (state_q)
        LCCR_ST_SUSPEND: state_d = present_s ? LCCR_ST_PRECOND : LCCR_ST_NOBAT;
        LCCR_ST_PRECOND: begin
          if (!present_s) begin
            state_d = LCCR_ST_SUSPEND;
          end else if (precond_ok_s) begin
            state_d = LCCR_ST_FAST;
          end else if (pre_exp || tot_exp) begin
            state_d = LCCR_ST_FAULT;
          end
        end
        LCCR_ST_FAST: begin
          if (!present_s) begin
            state_d = LCCR_ST_SUSPEND;
          end else if (tot_exp) begin
            state_d = LCCR_ST_FAULT;
          end else if (at_term_s) begin
            state_d = LCCR_ST_TOPOFF;
          end
        end
        LCCR_ST_TOPOFF: begin
          if (!present_s) begin
            state_d = LCCR_ST_SUSPEND;
          end else if (tot_exp) begin
            state_d = LCCR_ST_FAULT;
          end else if (eoc_s) begin
            state_d = LCCR_ST_SLEEP;
          end
        end
        LCCR_ST_SLEEP: begin
          if (!present_s) begin
            state_d = LCCR_ST_SUSPEND;
          end else if (restart_s) begin
            state_d = LCCR_ST_FAST;
          end
        end
        LCCR_ST_FAULT: state_d = present_s ? LCCR_ST_FAULT : LCCR_ST_SUSPEND;
        LCCR_ST_NOBAT: state_d = present_s ? LCCR_ST_PRECOND : LCCR_ST_NOBAT;
        default: state_d = LCCR_ST_SUSPEND;
      endcase
    end
  end

  // Health flag stays low after a fault until the precondition state is entered again
  logic fault_seen_q;
  logic charging, unit_on;
  assign charging = timing;
  // No-battery mode keeps the loop running as a voltage regulator
  assign unit_on = timing || (state_q == LCCR_ST_NOBAT);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= LCCR_ST_SUSPEND;
      fault_seen_q <= 1'b0;
      charger_unit_en_o <= 1'b0;
      cc_mode_o <= 1'b0;
      cv_mode_o <= 1'b0;
      precond_mode_o <= 1'b0;
      ldo123_en_o <= 1'b0;
      charge_current_monitor_oe_n_o <= 1'b1;
      fast_current_sel_o <= LCCR_CURRENT_RST;
      term_voltage_sel_o <= LCCR_VOLT_RST;
    end else begin
      state_q <= state_d;
      if (state_q == LCCR_ST_FAULT) begin
        fault_seen_q <= 1'b1;
      end else if (state_q == LCCR_ST_PRECOND) begin
        fault_seen_q <= 1'b0;
      end
      charger_unit_en_o <= unit_on && may_run;
      cc_mode_o <= (state_q == LCCR_ST_FAST) || (state_q == LCCR_ST_PRECOND);
      cv_mode_o <= (state_q == LCCR_ST_TOPOFF) || (state_q == LCCR_ST_NOBAT);
      precond_mode_o <= (state_q == LCCR_ST_PRECOND);
      ldo123_en_o <= above_uvlo_s;
      charge_current_monitor_oe_n_o <= !(unit_on && may_run);
      fast_current_sel_o <= fast_current_sel_q;
      term_voltage_sel_o <= term_voltage_sel_q;
    end
  end

  // ----------------------------------------
  // Read-back
  // ----------------------------------------
  logic [7:0] rd_d;
  assign rd_d = (reg_addr_i == LCCR_ADDR_SETPOINTS) ? {fast_current_sel_q, 1'b0, term_voltage_sel_q} :
                (reg_addr_i == LCCR_ADDR_STATUS) ? {safety_timeout_sel_q, 1'b0, !present_s,
                  (state_q == LCCR_ST_FAULT), 1'b0, charging, supply_ok} :
                (reg_addr_i == LCCR_ADDR_SUSPEND) ? {6'h00, !fault_seen_q && state_q != LCCR_ST_FAULT,
                  suspend_charge_q} :
                8'h00;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= rd_d;
    end
  end
endmodule

// ===== sim/lccr_charger_chk.sv
// Concurrent assertions on the charger control ports
`timescale 1ns/1ps
module lccr_charger_chk import lccr_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic charge_enable_n_i,
  input wire logic supply_above_uvlo_i,
  input wire logic charger_unit_en_o,
  input wire logic [3:0] fast_current_sel_o,
  input wire logic [2:0] term_voltage_sel_o,
  input wire logic ldo123_en_o,
  input wire logic charge_current_monitor_oe_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------
  // Write sequences
  // ----------------
  sequence s_set_wr;
    reg_wr_i && reg_addr_i == LCCR_ADDR_SETPOINTS ##1 !reg_wr_i [*2];
  endsequence
  sequence s_susp_set;
    reg_wr_i && reg_addr_i == LCCR_ADDR_SUSPEND && reg_wdata_i[0];
  endsequence
  sequence s_susp_wr;
    reg_wr_i && reg_addr_i == LCCR_ADDR_SUSPEND ##1 !reg_wr_i && reg_addr_i == LCCR_ADDR_SUSPEND;
  endsequence
  AST_CUR_SEL: assert property (s_set_wr |-> fast_current_sel_o == $past(reg_wdata_i[7:4], 2))
    else $error("current code differs from write");
  AST_VOLT_SEL: assert property (s_set_wr |-> term_voltage_sel_o == $past(reg_wdata_i[2:0], 2))
    else $error("voltage code differs from write");
  AST_SUSP_BIT: assert property (s_susp_wr |=> reg_rdata_o[0] == $past(reg_wdata_i[0], 2))
    else $error("suspend bit reads wrong");
  AST_RES_RO: assert property (reg_addr_i == LCCR_ADDR_RESERVED |=> reg_rdata_o == 8'h00)
    else $error("reserved byte not zero");
  AST_SUSP_RO: assert property (reg_addr_i == LCCR_ADDR_SUSPEND |=> reg_rdata_o[7:2] == 6'h00)
    else $error("suspend byte upper bits not zero");
  AST_SUSP_OFF: assert property (s_susp_set |-> ##[1:2] !charger_unit_en_o)
    else $error("charger on after suspend");
  AST_PIN_OFF: assert property (charge_enable_n_i [*5] |=> !charger_unit_en_o)
    else $error("charger on with pin high");
  AST_UVLO_OFF: assert property (!supply_above_uvlo_i [*5] |=> !charger_unit_en_o)
    else $error("charger on without supply");
  AST_LDO: assert property ($stable(supply_above_uvlo_i) [*5] |-> ldo123_en_o == supply_above_uvlo_i)
    else $error("regulator enable wrong");
  // Monitor enable switches on the same edge as the charger enable
  AST_MON_HIZ: assert property ($stable(charger_unit_en_o) [*2] |->
    charge_current_monitor_oe_n_o == !charger_unit_en_o)
    else $error("monitor drive wrong");
endmodule
bind lccr_charger_ctrl lccr_charger_chk i_chk (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .reg_wr_i(reg_wr_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o),
  .charge_enable_n_i(charge_enable_n_i),
  .supply_above_uvlo_i(supply_above_uvlo_i),
  .charger_unit_en_o(charger_unit_en_o),
  .fast_current_sel_o(fast_current_sel_o),
  .term_voltage_sel_o(term_voltage_sel_o),
  .ldo123_en_o(ldo123_en_o),
  .charge_current_monitor_oe_n_o(charge_current_monitor_oe_n_o)
);

// ===== sim/lccr_host_model.sv
// Host model issuing byte writes and address reads on the register port
`timescale 1ns/1ps
module lccr_host_model (
  input wire logic clk_i,
  output logic reg_wr_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o
);
  initial begin
    reg_wr_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  // One strobe per byte, then idle edges; data is scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    reg_wr_o = 1'b1;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(posedge clk_i);
    #1;
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
    @(posedge clk_i);
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    #1;
    reg_addr_o = a;
  endtask
endmodule

// ===== sim/liion_charger_control_regs_tb.sv
// Self-checking bench for the charger control block
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module liion_charger_control_regs_tb import lccr_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wr, en_n, abv, uvlo, pres, pre_ok, at_term, eoc, rst_cell, en, cc, cv, pre, ldo, oe_n;
  logic rd_req = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] addr, wdata, rdata, m, e;
  logic [3:0] isel;
  logic [2:0] vsel;
  logic [31:0] seed = 32'h9cd1;
  logic [7:0] exp_q[$];
  logic [7:0] msk_q[$];
  int error_cnt = 0;
  int check_count = 0;
  int n;
  localparam int TICK = 4;
  lccr_host_model i_host (.clk_i(clk_i), .reg_wr_o(wr), .reg_addr_o(addr), .reg_wdata_o(wdata));
  lccr_charger_ctrl #(.TICK_CYC(TICK)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(wr), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .charge_enable_n_i(en_n), .supply_above_cell_i(abv),
    .supply_above_uvlo_i(uvlo), .cell_presence_input_i(pres), .cell_above_precond_i(pre_ok),
    .cell_at_term_i(at_term), .current_below_eoc_i(eoc), .cell_below_restart_i(rst_cell),
    .charger_unit_en_o(en), .cc_mode_o(cc), .cv_mode_o(cv), .precond_mode_o(pre), .fast_current_sel_o(isel),
    .term_voltage_sel_o(vsel), .ldo123_en_o(ldo), .charge_current_monitor_oe_n_o(oe_n));
  initial forever #4 clk_i = ~clk_i;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic step(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] mk, input logic [7:0] ex);
    i_host.rd(a);
    msk_q.push_back(mk);
    exp_q.push_back(ex & mk);
    rd_req = 1'b1;
    step(1);
    rd_req = 1'b0;
    step(1);
  endtask
  task automatic cycle_susp();
    i_host.wr(LCCR_ADDR_SUSPEND, 8'h01);
    i_host.wr(LCCR_ADDR_SUSPEND, 8'h00);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Counts edges from the timer clear until the charger drops out; a hang ends the run
  task automatic time_fault(input int x);
    `CHK(en, 1'b1)
    n = 8;
    while (en === 1'b1) begin
      step(1);
      n++;
      if (n > x + 200) begin
        error_cnt++;
        finish_test();
      end
    end
    `CHK(n inside {[x - 5:x + 15]}, 1'b1)
  endtask
  // Read data lags the address by one edge, so the note is taken one edge late
  always @(posedge clk_i) begin
    if (rd_d) begin
      m = msk_q.pop_front();
      e = exp_q.pop_front();
      `CHK(rdata & m, e)
    end
    rd_d <= rd_req;
  end
  initial begin
    #200us;
    error_cnt++;
    finish_test();
  end
  initial begin
    {en_n, abv, uvlo, pres, pre_ok, at_term, eoc, rst_cell} = 8'b01010000;
    step(4);
    rst_n_i = 1'b1;
    rd(LCCR_ADDR_SETPOINTS, 8'hff, 8'h45);
    `CHK({ldo, en, oe_n}, 3'b001)
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      i_host.wr(LCCR_ADDR_SETPOINTS, seed[7:0]);
      rd(LCCR_ADDR_SETPOINTS, 8'hff, seed[7:0] & 8'hf7);
      `CHK({isel, vsel}, {seed[7:4], seed[2:0]})
      i_host.wr(LCCR_ADDR_STATUS, {2'(i), seed[13:8]});
      rd(LCCR_ADDR_STATUS, 8'he4, {2'(i), 6'h00});
      i_host.wr(LCCR_ADDR_RESERVED, seed[23:16]);
      rd(LCCR_ADDR_RESERVED, 8'hff, 8'h00);
      i_host.wr(LCCR_ADDR_SUSPEND, seed[31:24]);
      rd(LCCR_ADDR_SUSPEND, 8'hfd, {7'h00, seed[24]});
    end
    i_host.wr(LCCR_ADDR_SUSPEND, 8'h00);
    i_host.wr(LCCR_ADDR_STATUS, 8'h00);
    $display("test registers done");
    uvlo = 1'b1;
    step(6);
    `CHK({ldo, en, cc, pre, cv, oe_n}, 6'b111100)
    rd(LCCR_ADDR_STATUS, 8'h1b, 8'h03);
    pre_ok = 1'b1;
    step(6);
    `CHK({en, cc, pre, cv}, 4'b1100)
    at_term = 1'b1;
    step(6);
    `CHK({en, cc, cv}, 3'b101)
    eoc = 1'b1;
    step(6);
    `CHK({en, oe_n}, 2'b01)
    rd(LCCR_ADDR_STATUS, 8'h02, 8'h00);
    {at_term, eoc, rst_cell} = 3'b001;
    step(6);
    `CHK({en, cc, pre}, 3'b110)
    rst_cell = 1'b0;
    $display("test walk done");
    en_n = 1'b1;
    step(6);
    `CHK({en, oe_n}, 2'b01)
    {en_n, abv} = 2'b00;
    step(6);
    `CHK(en, 1'b0)
    abv = 1'b1;
    step(6);
    `CHK(en, 1'b1)
    i_host.wr(LCCR_ADDR_SUSPEND, 8'h01);
    step(2);
    `CHK(en, 1'b0)
    rd(LCCR_ADDR_SUSPEND, 8'h03, 8'h03);
    i_host.wr(LCCR_ADDR_SUSPEND, 8'h00);
    pres = 1'b0;
    step(8);
    `CHK({en, cc, cv}, 3'b101)
    rd(LCCR_ADDR_STATUS, 8'h10, 8'h10);
    pres = 1'b1;
    $display("test stops done");
    i_host.wr(LCCR_ADDR_STATUS, 8'h80);
    pre_ok = 1'b0;
    step(6);
    cycle_susp();
    step(8);
    time_fault(LCCR_PRE_30M_DMIN * TICK);
    rd(LCCR_ADDR_STATUS, 8'h0a, 8'h08);
    rd(LCCR_ADDR_SUSPEND, 8'h02, 8'h00);
    pre_ok = 1'b1;
    step(6);
    `CHK(en, 1'b0)
    cycle_susp();
    step(6);
    `CHK(en, 1'b1)
    rd(LCCR_ADDR_SUSPEND, 8'h02, 8'h02);
    i_host.wr(LCCR_ADDR_STATUS, 8'hc0);
    pre_ok = 1'b0;
    step(6);
    cycle_susp();
    step(8);
    time_fault(LCCR_PRE_45M_DMIN * TICK);
    i_host.wr(LCCR_ADDR_STATUS, 8'h80);
    pre_ok = 1'b1;
    step(6);
    cycle_susp();
    step(8);
    time_fault(LCCR_TOT_1H5_DMIN * TICK);
    rd(LCCR_ADDR_STATUS, 8'h0a, 8'h08);
    i_host.wr(LCCR_ADDR_STATUS, 8'h40);
    pre_ok = 1'b0;
    step(6);
    cycle_susp();
    step(2600);
    `CHK({en, pre}, 2'b11)
    $display("test timers done");
    finish_test();
  end
endmodule
